// File: hw/mnc_addr_gen.sv
`default_nettype none
// Resolves the 8-bit file field of a byte instruction to a data address.
module mnc_addr_gen import mnc_pkg::*; (
  // Instruction fields.
  input  wire logic        access_bit,
  input  wire logic [7:0]  file_addr,
  // Core state.
  input  wire logic [5:0]  bank_select_register,
  input  wire logic        ext_set_en,
  input  wire logic [13:0] index_base,
  // Result.
  output logic [13:0] data_addr
);
  wire use_indexed = !access_bit && ext_set_en &&
                     (file_addr <= ILO_LIMIT);
  wire [13:0] access_addr = (file_addr < ACCESS_SPLIT) ?
                            {6'h00, file_addr} :
                            {ACCESS_HI_BNK, file_addr};
  wire [13:0] banked_addr = {bank_select_register, file_addr};
  wire [13:0] indexed_addr = index_base + {6'h00, file_addr};
  assign data_addr = use_indexed ? indexed_addr :
                     (access_bit ? banked_addr : access_addr);
endmodule
`default_nettype wire

// File: hw/mnc_exec.sv
`default_nettype none
// Executes multiply, negate, nop, pop, push, relative call and reset.
module mnc_exec import mnc_pkg::*; (
  // Clocking.
  input  wire logic         clock,
  input  wire logic         resetn,
  input  wire logic         clk_en,
  // Instruction from decode, one per instruction cycle.
  input  wire logic         instr_valid,
  input  wire logic [15:0]  instr,
  // Core state read by this block.
  input  wire logic [7:0]   work_reg,
  input  wire logic [5:0]   bank_select_register,
  input  wire logic         ext_set_en,
  input  wire logic [13:0]  index_base,
  input  wire logic [7:0]   mem_rdata,
  // Data memory.
  output mnc_mem_req_t      mem_req,
  // Return stack.
  output mnc_stack_req_t    stack_req,
  // Results.
  output logic [7:0]        product_high,
  output logic [7:0]        product_low,
  output logic [4:0]        status_flags,
  output logic [20:0]       prog_counter,
  output logic              soft_reset,
  output logic              busy
);
  mnc_state_t   state_r, state_nxt;
  logic [7:0]   prod_hi_r, prod_lo_r;
  logic [4:0]   flags_r;
  logic [20:0]  pc_r, pc_nxt;
  logic [20:0]  call_target_r;

  // Every check in this module runs on the core clock under reset.
  default clocking mnc_cb @(posedge clock);
  endclocking
  default disable iff (!resetn);

  // The decoders look only at the word. Gating with run keeps a busy or
  // frozen core deaf to whatever decode presents in that cycle.
  wire run = clk_en && instr_valid && (state_r == MNC_ST_RUN);
  wire is_mullit = instr[15:8] == MULLIT_OPC;
  wire is_mulreg = instr[15:9] == MULREG_OPC;
  wire is_neg    = instr[15:9] == NEGATE_OPC;
  wire is_rel_call = instr[15:11] == REL_CALL_OPC;
  wire is_pop    = instr == POP_WORD;
  wire is_push   = instr == PUSH_WORD;
  wire is_reset  = instr == RESET_WORD;
  wire is_nop    = (instr == NOP_WORD) ||
                   (instr[15:12] == NOP_ALT_OPC);

  logic [13:0] file_addr;
  mnc_addr_gen u_addr (
    .access_bit           (instr[8]),
    .file_addr            (instr[7:0]),
    .bank_select_register (bank_select_register),
    .ext_set_en           (ext_set_en),
    .index_base           (index_base),
    .data_addr            (file_addr)
  );

  // Data memory must answer within the cycle: both the register multiply
  // and the negate read mem_rdata combinationally. A slower memory would
  // need a wait state here, which the single-cycle timing does not allow.
  wire [7:0]  mul_opnd = is_mullit ? instr[7:0] : mem_rdata;
  wire [15:0] product  = work_reg * mul_opnd;
  wire [7:0]  neg_res  = 8'h00 - mem_rdata;
  // Negation is a subtraction from zero, so carry and digit carry mean
  // that no borrow occurred.
  wire [4:0]  neg_flags;
  assign neg_flags[FLAG_N]  = neg_res[7];
  assign neg_flags[FLAG_OV] = mem_rdata == 8'h80;
  assign neg_flags[FLAG_Z]  = neg_res == 8'h00;
  assign neg_flags[FLAG_DC] = mem_rdata[3:0] == 4'h0;
  assign neg_flags[FLAG_C]  = mem_rdata == 8'h00;
  wire [20:0] ret_addr = pc_r + PC_STEP;
  wire [20:0] rel_off  = {{9{instr[10]}}, instr[10:0], 1'b0};

  // A call and a reset each hold one extra cycle, during which busy
  // refuses new words. This costs a cycle but keeps fetch out of the way.
  always_comb begin
    state_nxt = state_r;
    pc_nxt    = pc_r;
    if (clk_en) begin
      case (state_r)
        MNC_ST_RUN: begin
          if (instr_valid) begin
            pc_nxt = ret_addr;
            if (is_reset) begin
              state_nxt = MNC_ST_RST;
            end else if (is_rel_call) begin
              state_nxt = MNC_ST_CALL2;
            end
          end
        end
        MNC_ST_CALL2: begin
          pc_nxt    = call_target_r;
          state_nxt = MNC_ST_RUN;
        end
        MNC_ST_RST: begin
          pc_nxt    = PC_RESET;
          state_nxt = MNC_ST_RUN;
        end
        default: begin
          state_nxt = MNC_ST_RUN;
        end
      endcase
    end
  end

  // Clock enable low keeps every register here, the call target included.
  always_ff @(posedge clock or negedge resetn) begin
    if (!resetn) begin
      state_r       <= MNC_ST_RUN;
      pc_r          <= PC_RESET;
      call_target_r <= PC_RESET;
    end else begin
      state_r <= state_nxt;
      pc_r    <= pc_nxt;
      if (run && is_rel_call) begin
        call_target_r <= ret_addr + rel_off;
      end
    end
  end

  // A software reset clears results alongside the rest of the core.
  always_ff @(posedge clock or negedge resetn) begin
    if (!resetn) begin
      prod_hi_r <= BYTE_RESET;
      prod_lo_r <= BYTE_RESET;
      flags_r   <= FLAGS_RESET;
    end else if (clk_en && state_r == MNC_ST_RST) begin
      prod_hi_r <= BYTE_RESET;
      prod_lo_r <= BYTE_RESET;
      flags_r   <= FLAGS_RESET;
    end else if (run && (is_mullit || is_mulreg)) begin
      prod_hi_r <= product[15:8];
      prod_lo_r <= product[7:0];
    end else if (run && is_neg) begin
      flags_r <= neg_flags;
    end
  end

  // Strobes are combinational so that the stack and the memory act in the
  // same cycle as the instruction that asks for them.
  assign mem_req.we    = run && is_neg;
  assign mem_req.addr  = file_addr;
  assign mem_req.wdata = neg_res;
  assign stack_req.push = run && (is_push || is_rel_call);
  assign stack_req.pop  = run && is_pop;
  assign stack_req.data = ret_addr;
  assign product_high = prod_hi_r;
  assign product_low  = prod_lo_r;
  assign status_flags = flags_r;
  assign prog_counter = pc_r;
  assign soft_reset   = state_r == MNC_ST_RST;
  assign busy         = state_r != MNC_ST_RUN;

  // Multiplies.
  mul_prod_a: assert property (
    run && is_mulreg |=> product_high == $past(product[15:8]))
    else $error("register multiply product wrong");
  mul_flags_a: assert property (
    run && (is_mullit || is_mulreg) |=> $stable(status_flags))
    else $error("multiply touched flags");
  lit_prod_a: assert property (
    run && is_mullit |=> {product_high, product_low} ==
      $past(work_reg) * $past({8'h00, instr[7:0]}))
    else $error("literal multiply product wrong");
  mul_quiet_a: assert property (
    run && (is_mullit || is_mulreg) |-> !mem_req.we)
    else $error("multiply wrote data memory");

  // Negate and stack.
  neg_write_a: assert property (
    mem_req.we |-> mem_req.wdata + mem_rdata == 8'h00)
    else $error("negate result wrong");
  pop_once_a: assert property (
    stack_req.pop |-> !stack_req.push)
    else $error("pop with push");
  stack_flags_a: assert property (
    run && (is_pop || is_push) |=> $stable(status_flags))
    else $error("stack operation touched flags");
  push_addr_a: assert property (
    stack_req.push |-> stack_req.data == prog_counter + PC_STEP)
    else $error("push address wrong");

  // Relative call.
  call_push_a: assert property (
    run && is_rel_call |-> stack_req.push)
    else $error("relative call did not push");
  call_wait_a: assert property (
    run && is_rel_call |=> busy && prog_counter == $past(ret_addr))
    else $error("relative call first cycle wrong");
  call_jump_a: assert property (
    clk_en && state_r == MNC_ST_CALL2 |=>
      !busy && prog_counter == $past(call_target_r))
    else $error("relative call target wrong");
  busy_quiet_a: assert property (
    busy |-> !stack_req.push && !stack_req.pop && !mem_req.we)
    else $error("strobe while busy");

  // Reset, no-operation and clock enable.
  rst_start_a: assert property (
    run && is_reset |=> soft_reset)
    else $error("software reset not started");
  rst_clear_a: assert property (
    clk_en && soft_reset |=> prog_counter == PC_RESET &&
      product_high == BYTE_RESET && product_low == BYTE_RESET &&
      status_flags == FLAGS_RESET)
    else $error("software reset left state");
  nop_keep_a: assert property (
    run && is_nop |=> $stable(product_high) && $stable(status_flags))
    else $error("nop changed state");
  nop_quiet_a: assert property (
    run && is_nop |-> !stack_req.push && !stack_req.pop && !mem_req.we)
    else $error("nop raised a strobe");
  freeze_a: assert property (
    !clk_en |=> $stable(prog_counter) && $stable(busy) &&
      $stable(status_flags) && $stable(product_low))
    else $error("state moved with clock enable low");

  // Main scenarios.
  ptr_c: cover property (@(posedge clock) run && is_mulreg);
  call_c: cover property (@(posedge clock) run && is_rel_call ##1 busy);
  neg_c: cover property (@(posedge clock) mem_req.we);
  rst_c: cover property (@(posedge clock) soft_reset);
  stack_c: cover property (@(posedge clock) stack_req.pop ##1 stack_req.push);
endmodule
`default_nettype wire

// File: inc/mnc_pkg.sv
// Functional notes
// - Literal multiply puts unsigned W times literal in product pair.
// - Neither multiply changes any status flag, even for a zero product.
// - Register multiply puts unsigned W times register in product pair.
// - Register multiply decodes as 0000 001, access bit, file address.
// - Access bit 0 selects access bank; 1 takes bank from bank select.
// - Access bit 0, extended set on, address up to 95 uses indexed offset.
// - Negate writes two's complement back and updates N, OV, C, DC, Z.
// - Stack pop discards top of stack in one cycle, no status change.
// - Stack push places program counter plus 2 on the stack in one cycle.
// - Relative call first pushes program counter plus 2 as return address.
// - Relative call then jumps by twice the offset, second cycle idle.
// - Software reset restores all state as the master clear pin would; here call_target_r keeps its value.
`default_nettype none
package mnc_pkg;
  localparam logic [6:0]  MULREG_OPC    = 7'h01;
  localparam logic [7:0]  MULLIT_OPC    = 8'h0D;
  localparam logic [6:0]  NEGATE_OPC    = 7'h36;
  localparam logic [4:0]  REL_CALL_OPC  = 5'h1B;
  localparam logic [15:0] NOP_WORD      = 16'h0000;
  localparam logic [3:0]  NOP_ALT_OPC   = 4'hF;
  localparam logic [15:0] POP_WORD      = 16'h0006;
  localparam logic [15:0] PUSH_WORD     = 16'h0005;
  localparam logic [15:0] RESET_WORD    = 16'h00FF;
  localparam logic [7:0]  ILO_LIMIT     = 8'h5F;
  localparam logic [7:0]  ACCESS_SPLIT  = 8'h60;
  localparam logic [5:0]  ACCESS_HI_BNK = 6'h3F;
  localparam logic [20:0] PC_STEP       = 21'h000002;
  localparam logic [20:0] PC_RESET      = 21'h000000;
  localparam logic [7:0]  BYTE_RESET    = 8'h00;
  localparam logic [4:0]  FLAGS_RESET   = 5'h00;
  localparam int          FLAG_N = 4;
  localparam int          FLAG_OV = 3;
  localparam int          FLAG_Z = 2;
  localparam int          FLAG_DC = 1;
  localparam int          FLAG_C = 0;
  typedef enum logic [2:0] {
    MNC_ST_RUN   = 3'b001,
    MNC_ST_CALL2 = 3'b010,
    MNC_ST_RST   = 3'b100
  } mnc_state_t;
  typedef struct packed {
    logic        we;
    logic [13:0] addr;
    logic [7:0]  wdata;
  } mnc_mem_req_t;
  typedef struct packed {
    logic        push;
    logic        pop;
    logic [20:0] data;
  } mnc_stack_req_t;
endpackage
`default_nettype wire

// File: testbench/tb_top.sv
`default_nettype none
module tb_top;
  timeunit 1ns;
  timeprecision 1ps;
  import mnc_pkg::*;
  logic           clock = 1'b0;
  logic           resetn = 1'b0;
  logic           clk_en = 1'b1;
  logic           instr_valid = 1'b0;
  logic [15:0]    instr = 16'h0000;
  logic [7:0]     work_reg = 8'h00;
  logic [5:0]     bank_sel = 6'h00;
  logic           ext_set_en = 1'b0;
  logic [13:0]    index_base = 14'h0100;
  logic [7:0]     mem_rdata = 8'h00;
  mnc_mem_req_t   mem_req;
  mnc_stack_req_t stack_req;
  logic [7:0]     product_high;
  logic [7:0]     product_low;
  logic [4:0]     status_flags;
  logic [20:0]    prog_counter;
  logic           soft_reset;
  logic           busy;
  int             err_total = 0;
  int             n_tests = 0;
  logic [20:0]    exp_pc = 21'h000000;
  mnc_mem_req_t   mq;
  mnc_stack_req_t sq;
  mnc_exec mnc_exec_inst (.clock(clock), .resetn(resetn), .clk_en(clk_en),
    .instr_valid(instr_valid), .instr(instr), .work_reg(work_reg),
    .bank_select_register(bank_sel), .ext_set_en(ext_set_en),
    .index_base(index_base), .mem_rdata(mem_rdata), .mem_req(mem_req),
    .stack_req(stack_req), .product_high(product_high),
    .product_low(product_low), .status_flags(status_flags),
    .prog_counter(prog_counter), .soft_reset(soft_reset), .busy(busy));
  always #12.5 clock = ~clock;
  task automatic final_report;
    $display("errors %0d checks %0d", err_total, n_tests);
    if (err_total == 0 && n_tests > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask
  task automatic chk(input logic [31:0] got, exp, input string m);
    n_tests++;
    if (got !== exp) begin
      err_total++;
      $display("[ERR] %0t %s", $time, m);
    end
  endtask
  // Strobes are combinational, so they are captured inside the cycle.
  task automatic exec(input logic [15:0] w);
    instr = w;
    instr_valid = 1'b1;
    #5;
    mq = mem_req;
    sq = stack_req;
    @(posedge clock);
    #2;
    if (clk_en) exp_pc = exp_pc + 21'h000002;
  endtask
  task automatic idle;
    instr_valid = 1'b0;
    @(posedge clock);
    #2;
  endtask
  task automatic neg_case(input logic [15:0] w, input logic [7:0] rd,
      input logic [13:0] ad, input logic [7:0] res, input logic [4:0] fl);
    mem_rdata = rd;
    exec(w);
    chk(mq.we, 1'b1, "negate no write");
    chk(mq.addr, ad, "negate address");
    chk(mq.wdata, res, "negate result");
    chk(status_flags, fl, "negate flags");
  endtask
  task automatic t_negate;
    bank_sel = 6'h05;
    neg_case(16'h6D10, 8'h3A, 14'h0510, 8'hC6, 5'h10);
    neg_case(16'h6C80, 8'h80, 14'h3F80, 8'h80, 5'h1A);
    neg_case(16'h6C05, 8'h00, 14'h0005, 8'h00, 5'h07);
  endtask
  task automatic mul_case(input logic [15:0] w, input logic [7:0] wr, rd,
      input logic [13:0] ad, input logic [15:0] p);
    work_reg = wr;
    mem_rdata = rd;
    exec(w);
    if (w[15:8] != 8'h0D) chk(mq.addr, ad, "multiply address");
    chk(mq.we, 1'b0, "multiply wrote memory");
    chk({product_high, product_low}, p, "product");
    chk(status_flags, 5'h07, "multiply touched flags");
  endtask
  task automatic t_multiply;
    mul_case(16'h0DC4, 8'hE2, 8'h00, 14'h0000, 16'hAD08);
    mul_case(16'h0310, 8'hC4, 8'hB5, 14'h0510, 16'h8A94);
    ext_set_en = 1'b1;
    mul_case(16'h025F, 8'hFF, 8'hFF, 14'h015F, 16'hFE01);
    mul_case(16'h0260, 8'h00, 8'h12, 14'h3F60, 16'h0000);
    ext_set_en = 1'b0;
  endtask
  task automatic t_stack;
    exec(16'h0006);
    chk({sq.pop, sq.push}, 2'b10, "pop strobe");
    chk(status_flags, 5'h07, "pop flags");
    exec(16'h0005);
    chk({sq.pop, sq.push}, 2'b01, "push strobe");
    chk(sq.data, exp_pc, "push data");
  endtask
  task automatic t_call;
    logic [10:0] offs [2] = '{11'h7FF, 11'h3FF};
    logic [20:0] tgt;
    foreach (offs[i]) begin
      tgt = exp_pc + 21'h000002 + {{9{offs[i][10]}}, offs[i], 1'b0};
      exec({5'h1B, offs[i]});
      chk(sq.push, 1'b1, "call push");
      chk(sq.data, exp_pc, "call return address");
      chk({busy, prog_counter}, {1'b1, exp_pc}, "call cycle one");
      exec(16'h0005);
      chk(sq.push, 1'b0, "push taken while busy");
      chk({busy, prog_counter}, {1'b0, tgt}, "call target");
      exp_pc = tgt;
    end
    idle();
  endtask
  task automatic t_nop;
    work_reg = 8'hE2;
    exec(16'h0DC4);
    exec(16'h0000);
    exec(16'hF123);
    chk({sq.push, sq.pop, mq.we}, 3'b000, "nop strobes");
    chk(prog_counter, exp_pc, "nop pc");
    chk({product_high, product_low, status_flags}, 21'h15A107,
      "nop state");
    clk_en = 1'b0;
    exec(16'h0000);
    chk(prog_counter, exp_pc, "pc moved with clock enable low");
    clk_en = 1'b1;
    idle();
  endtask
  task automatic t_reset;
    exec(16'h00FF);
    chk(soft_reset, 1'b1, "soft reset missing");
    chk(busy, 1'b1, "soft reset not busy");
    idle();
    chk({product_high, product_low, status_flags}, 21'h000000,
      "state kept");
    chk(prog_counter, 21'h000000, "pc not cleared");
    chk(soft_reset, 1'b0, "soft reset stuck");
    exp_pc = 21'h000000;
  endtask
  initial begin
    #50000;
    err_total++;
    $display("[ERR] %0t watchdog expired", $time);
    final_report();
  end
  initial begin
    repeat (10) @(posedge clock);
    #2;
    resetn = 1'b1;
    t_negate();
    t_multiply();
    t_stack();
    t_call();
    t_nop();
    t_reset();
    final_report();
  end
endmodule
`default_nettype wire
